//--- fsi_pkg.sv
// Package of constants and types for the float to integer store converter.
package fsi_pkg;

  // Register map, byte addresses.
  localparam logic [7:0] FSI_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] FSI_ADDR_STATUS = 8'h04;
  localparam logic [7:0] FSI_ADDR_MASK   = 8'h08;

  // Control register fields.
  localparam int FSI_CTRL_RMODE_LSB = 0;
  localparam int FSI_CTRL_IMASK_BIT = 2;

  // Status and mask register fields.
  localparam int FSI_STS_INV  = 0;
  localparam int FSI_STS_PREC = 1;
  localparam int FSI_STS_DONE = 2;
  localparam int FSI_STS_W    = 3;

  // Reset values.
  localparam logic [1:0]         FSI_RST_RMODE = 2'h0;
  localparam logic               FSI_RST_IMASK = 1'b1;
  localparam logic [FSI_STS_W-1:0] FSI_RST_MASK = 3'h0;

  // Extended precision operand layout.
  localparam int              FSI_OP_W     = 80;
  localparam int              FSI_SIGN_BIT = 79;
  localparam int              FSI_EXP_MSB  = 78;
  localparam int              FSI_EXP_LSB  = 64;
  localparam logic [14:0]     FSI_EXP_BIAS = 15'h3FFF;
  localparam logic [14:0]     FSI_EXP_BIG  = 15'h403F;
  localparam logic [14:0]     FSI_EXP_TINY = 15'h3FBF;
  localparam logic [14:0]     FSI_SH_BASE  = 15'h403E;

  // Integer indefinite patterns for each target width.
  localparam logic [63:0] FSI_INDEF16 = 64'h0000_0000_0000_8000;
  localparam logic [63:0] FSI_INDEF32 = 64'h0000_0000_8000_0000;
  localparam logic [63:0] FSI_INDEF64 = 64'h8000_0000_0000_0000;

  // Largest positive magnitude for each target width.
  localparam logic [64:0] FSI_MAX16 = 65'h0_0000_0000_0000_7FFF;
  localparam logic [64:0] FSI_MAX32 = 65'h0_0000_0000_7FFF_FFFF;
  localparam logic [64:0] FSI_MAX64 = 65'h0_7FFF_FFFF_FFFF_FFFF;

  typedef enum logic [1:0] {
    FSI_SIZE_16 = 2'h0,
    FSI_SIZE_32 = 2'h1,
    FSI_SIZE_64 = 2'h2
  } fsi_size_t;

  typedef enum logic [1:0] {
    FSI_RND_NEAREST = 2'h0,
    FSI_RND_DOWN    = 2'h1,
    FSI_RND_UP      = 2'h2,
    FSI_RND_ZERO    = 2'h3
  } fsi_rnd_t;

endpackage

//--- fsi_store_convert.sv
// Float to integer store converter with status, interrupt and register port.
//
// What this block does
// RULE_01 - A masked out-of-range conversion stores the integer indefinite pattern of the width.
// RULE_02 - Any operand that cannot be represented in the chosen width sets the invalid flag.
// RULE_03 - A conversion that is invalid never sets the precision flag.
// RULE_04 - Range detection depends on the rounding mode, since the rounded value is checked.
// RULE_05 - Targets of 16, 32 and 64 bits are supported and range is checked for the chosen one.
// RULE_06 - Negative operands below the most negative integer, however far, are detected.
// RULE_07 - The store-and-pop variant pops the operand once the masked store has been issued.
// RULE_08 - In the masked case the invalid status bit is set as well.
// RULE_09 - When unmasked, nothing is stored and the operand is neither altered nor popped.
// RULE_10 - When unmasked, the invalid flag is set and the numeric exception handler is entered.
// RULE_11 - The range check uses the rounded integer value.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module fsi_store_convert (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  cvt_valid_i,
  input  wire logic [79:0]           cvt_operand_i,
  input  wire fsi_pkg::fsi_size_t    cvt_size_i,
  input  wire logic                  cvt_pop_i,
  output logic                       store_valid_o,
  output logic [63:0]                store_data_o,
  output fsi_pkg::fsi_size_t         store_size_o,
  output logic                       pop_o,
  output logic                       fault_o,
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [31:0]                reg_rdata_o,
  output logic                       irq_o
);
  import fsi_pkg::*;

  typedef struct packed {
    logic [1:0]           rmode;
    logic                 imask;
    logic [FSI_STS_W-1:0] irq_mask;
    logic [FSI_STS_W-1:0] sts;
    logic [31:0]          rdata;
    logic                 st_vld;
    logic [63:0]          st_data;
    fsi_size_t            st_size;
    logic                 pop;
    logic                 fault;
    logic                 last_inv;
    logic                 last_prec;
  } fsi_state_t;

  fsi_state_t st_r;
  fsi_state_t st_nxt;

  function automatic logic [64:0] fsi_limit(input fsi_size_t sz);
    unique case (sz)
      FSI_SIZE_16: fsi_limit = FSI_MAX16;
      FSI_SIZE_32: fsi_limit = FSI_MAX32;
      default:     fsi_limit = FSI_MAX64;
    endcase
  endfunction

  function automatic logic [63:0] fsi_indef(input fsi_size_t sz);
    unique case (sz)
      FSI_SIZE_16: fsi_indef = FSI_INDEF16;
      FSI_SIZE_32: fsi_indef = FSI_INDEF32;
      default:     fsi_indef = FSI_INDEF64;
    endcase
  endfunction

  function automatic logic [63:0] fsi_trim(input fsi_size_t sz, input logic [63:0] v);
    unique case (sz)
      FSI_SIZE_16: fsi_trim = {48'h0, v[15:0]};
      FSI_SIZE_32: fsi_trim = {32'h0, v[31:0]};
      default:     fsi_trim = v;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion datapath.

  logic          op_sign;
  logic [14:0]   op_exp;
  logic [63:0]   op_mant;
  logic          exp_big;
  logic          exp_tiny;
  logic [14:0]   sh_full;
  logic [127:0]  shifted;
  logic [63:0]   mag;
  logic          guard;
  logic          sticky;
  logic          lsb_inc;
  logic [64:0]   rounded;
  logic [64:0]   lim;
  logic          ovf;
  logic          inexact;
  logic [63:0]   signed_res;

  assign op_sign  = cvt_operand_i[FSI_SIGN_BIT];
  assign op_exp   = cvt_operand_i[FSI_EXP_MSB:FSI_EXP_LSB];
  assign op_mant  = cvt_operand_i[63:0];
  assign exp_big  = (op_exp >= FSI_EXP_BIG);
  assign exp_tiny = (op_exp < FSI_EXP_TINY);
  assign sh_full  = FSI_SH_BASE - op_exp;
  assign shifted  = {op_mant, 64'h0} >> sh_full[6:0];

  always_comb begin
    if (exp_tiny || exp_big) begin
      mag    = 64'h0;
      guard  = 1'b0;
      sticky = |op_mant;
    end else begin
      mag    = shifted[127:64];
      guard  = shifted[63];
      sticky = |shifted[62:0];
    end
  end

  // Increment decision per rounding mode; range logic below checks the rounded value, so it follows the mode. RULE_04
  always_comb begin
    unique case (fsi_rnd_t'(st_r.rmode))
      FSI_RND_NEAREST: lsb_inc = guard & (sticky | mag[0]);
      FSI_RND_DOWN:    lsb_inc = (guard | sticky) & op_sign;
      FSI_RND_UP:      lsb_inc = (guard | sticky) & ~op_sign;
      FSI_RND_ZERO:    lsb_inc = 1'b0;
    endcase
  end

  assign rounded = {1'b0, mag} + {64'h0, lsb_inc}; // RULE_11
  assign lim     = fsi_limit(cvt_size_i); // RULE_05
  // Negative side allows one more than the positive limit; anything further out, however far, is flagged. RULE_06
  assign ovf     = exp_big | (op_sign ? (rounded > (lim + 65'h1)) : (rounded > lim)); // RULE_02
  assign inexact = (guard | sticky) & ~ovf; // RULE_03
  assign signed_res = op_sign ? (~rounded[63:0] + 64'h1) : rounded[63:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  logic [FSI_STS_W-1:0] evt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rdata  = 32'h0;
    st_nxt.st_vld = 1'b0;
    st_nxt.pop    = 1'b0;
    st_nxt.fault  = 1'b0;
    evt           = '0;
    if (cvt_valid_i) begin
      st_nxt.last_inv  = ovf;
      st_nxt.last_prec = inexact;
      st_nxt.st_size   = cvt_size_i;
      evt[FSI_STS_INV]  = ovf; // RULE_08
      evt[FSI_STS_PREC] = inexact;
      evt[FSI_STS_DONE] = 1'b1;
      if (!ovf) begin
        st_nxt.st_vld  = 1'b1;
        st_nxt.st_data = fsi_trim(cvt_size_i, signed_res);
        st_nxt.pop     = cvt_pop_i;
      end else if (st_r.imask) begin
        st_nxt.st_vld  = 1'b1;
        st_nxt.st_data = fsi_indef(cvt_size_i); // RULE_01
        st_nxt.pop     = cvt_pop_i; // RULE_07
      end else begin
        st_nxt.fault   = 1'b1; // RULE_09 RULE_10
      end
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        FSI_ADDR_CTRL: begin
          st_nxt.rmode = reg_wdata_i[FSI_CTRL_RMODE_LSB +: 2];
          st_nxt.imask = reg_wdata_i[FSI_CTRL_IMASK_BIT];
        end
        FSI_ADDR_MASK: st_nxt.irq_mask = reg_wdata_i[FSI_STS_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        FSI_ADDR_CTRL:   st_nxt.rdata = {29'h0, st_r.imask, st_r.rmode};
        FSI_ADDR_STATUS: begin
          st_nxt.rdata = {29'h0, st_r.sts};
          st_nxt.sts   = '0;
        end
        FSI_ADDR_MASK:   st_nxt.rdata = {29'h0, st_r.irq_mask};
        default:         st_nxt.rdata = 32'h0;
      endcase
    end
    st_nxt.sts = st_nxt.sts | evt;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r          <= '0;
      st_r.rmode    <= FSI_RST_RMODE;
      st_r.imask    <= FSI_RST_IMASK;
      st_r.irq_mask <= FSI_RST_MASK;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign store_valid_o = st_r.st_vld;
  assign store_data_o  = st_r.st_data;
  assign store_size_o  = st_r.st_size;
  assign pop_o         = st_r.pop;
  assign fault_o       = st_r.fault;
  assign reg_rdata_o   = st_r.rdata;
  assign irq_o         = |(st_r.sts & st_r.irq_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_indef;
    @(posedge clk_i) disable iff (!rst_n_i)
      store_valid_o && st_r.last_inv |-> store_data_o == fsi_indef(store_size_o);
  endproperty
  a_indef: assert property (p_indef) else $error("Masked overflow did not store indefinite."); // RULE_01

  property p_nan_inv;
    @(posedge clk_i) disable iff (!rst_n_i)
      cvt_valid_i && (cvt_operand_i[78:64] == 15'h7FFF) |=> st_r.last_inv && st_r.sts[FSI_STS_INV];
  endproperty
  a_nan_inv: assert property (p_nan_inv) else $error("Huge operand not flagged invalid."); // RULE_02

  property p_no_prec;
    @(posedge clk_i) disable iff (!rst_n_i)
      st_r.last_inv |-> !st_r.last_prec;
  endproperty
  a_no_prec: assert property (p_no_prec) else $error("Precision set on invalid conversion."); // RULE_03

  property p_any_mode;
    @(posedge clk_i) disable iff (!rst_n_i)
      cvt_valid_i && cvt_operand_i[79] && (cvt_operand_i[78:64] == 15'h4020)
        && (cvt_size_i != FSI_SIZE_64) |=> st_r.last_inv;
  endproperty
  a_any_mode: assert property (p_any_mode) else $error("Mode suppressed overflow."); // RULE_04

  property p_size;
    @(posedge clk_i) disable iff (!rst_n_i)
      cvt_valid_i |=> store_size_o == $past(cvt_size_i);
  endproperty
  a_size: assert property (p_size) else $error("Store width does not match request."); // RULE_05

  property p_far_neg;
    @(posedge clk_i) disable iff (!rst_n_i)
      cvt_valid_i && cvt_operand_i[79] && (cvt_operand_i[78:64] >= FSI_EXP_BIG) |=> fault_o
        || (store_valid_o && st_r.last_inv);
  endproperty
  a_far_neg: assert property (p_far_neg) else $error("Far negative operand not detected."); // RULE_06

  property p_pop;
    @(posedge clk_i) disable iff (!rst_n_i)
      pop_o |-> store_valid_o && !fault_o;
  endproperty
  a_pop: assert property (p_pop) else $error("Pop without a store."); // RULE_07

  property p_masked_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
      store_valid_o && st_r.last_inv |-> st_r.sts[FSI_STS_INV] && $past(st_r.imask);
  endproperty
  a_masked_flag: assert property (p_masked_flag) else $error("Masked overflow left flag clear."); // RULE_08

  property p_unmasked;
    @(posedge clk_i) disable iff (!rst_n_i)
      fault_o |-> !store_valid_o && !pop_o && !$past(st_r.imask);
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("Unmasked overflow stored or popped."); // RULE_09

  property p_fault_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
      fault_o |-> st_r.sts[FSI_STS_INV] && st_r.last_inv;
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("Handler entered without flag."); // RULE_10

  property p_rounded_in;
    @(posedge clk_i) disable iff (!rst_n_i)
      cvt_valid_i && (cvt_size_i == FSI_SIZE_16) && (cvt_operand_i == 80'h400D_FFFE_0000_0000_0000)
        |=> store_valid_o && !st_r.last_inv && (store_data_o == 64'h0000_0000_0000_7FFF);
  endproperty
  a_rounded_in: assert property (p_rounded_in) else $error("Edge value stored wrongly."); // RULE_11

  property p_one_answer;
    @(posedge clk_i) disable iff (!rst_n_i)
      cvt_valid_i |=> store_valid_o != fault_o;
  endproperty
  a_one_answer: assert property (p_one_answer) // RULE_09
    else $error("Request answered by neither or both paths.");

  property p_big_no_prec;
    @(posedge clk_i) disable iff (!rst_n_i)
      cvt_valid_i && (cvt_operand_i[78:64] >= FSI_EXP_BIG) |=> st_r.last_inv && !st_r.last_prec;
  endproperty
  a_big_no_prec: assert property (p_big_no_prec) // RULE_03
    else $error("Big operand set precision.");

  property p_pos_16;
    @(posedge clk_i) disable iff (!rst_n_i)
      cvt_valid_i && !cvt_operand_i[79] && (cvt_size_i == FSI_SIZE_16)
        && (cvt_operand_i[78:64] == 15'h400E) |=> st_r.last_inv;
  endproperty
  a_pos_16: assert property (p_pos_16) // RULE_05
    else $error("Positive overflow of short target missed.");

  c_masked: cover property (@(posedge clk_i) disable iff (!rst_n_i) store_valid_o && st_r.last_inv);
  c_fault:  cover property (@(posedge clk_i) disable iff (!rst_n_i) fault_o);
  c_pop:    cover property (@(posedge clk_i) disable iff (!rst_n_i) pop_o && !st_r.last_inv);
  c_irq:    cover property (@(posedge clk_i) disable iff (!rst_n_i) irq_o);
  c_prec:   cover property (@(posedge clk_i) disable iff (!rst_n_i) st_r.last_prec);

endmodule

`default_nettype wire

//--- fsi_store_model.sv
// Model of the memory store path and register stack fed by the converter.
`timescale 1ns/100ps
`default_nettype none
module fsi_store_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        store_valid_i,
  input  wire logic [63:0] store_data_i,
  input  wire logic        pop_i,
  input  wire logic        fault_i,
  output logic [63:0]      mem_word_o,
  output logic [7:0]       n_store_o,
  output logic [7:0]       depth_o,
  output logic [7:0]       n_fault_o
);
  // Memory takes every store, the stack shrinks on each pop and faults are counted.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mem_word_o <= 64'h0;
      n_store_o  <= 8'h0;
      depth_o    <= 8'h08;
      n_fault_o  <= 8'h0;
    end else begin
      if (store_valid_i) begin
        mem_word_o <= store_data_i;
        n_store_o  <= n_store_o + 8'h01;
      end
      if (pop_i) begin
        depth_o <= depth_o - 8'h01;
      end
      if (fault_i) begin
        n_fault_o <= n_fault_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- float_to_int_store_convert_tb.sv
// Self-checking testbench for the float to integer store converter.
`timescale 1ns/100ps
`default_nettype none
module float_to_int_store_convert_tb;
  import fsi_pkg::*;
  typedef struct {
    logic [79:0] op;
    fsi_size_t   sz;
    logic [1:0]  rm;
    logic [63:0] dat;
    logic [1:0]  st;
  } fsi_case_t;
  localparam logic [79:0] NEG_HUGE = 80'hC045_8000_0000_0000_0000;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cvt_valid_i = 1'b0;
  logic [79:0] cvt_operand_i = 80'h0;
  fsi_size_t   cvt_size_i = FSI_SIZE_16;
  logic        cvt_pop_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        store_valid_o, pop_o, fault_o, irq_o;
  logic [63:0] store_data_o, mem_word;
  fsi_size_t   store_size_o;
  logic [31:0] reg_rdata_o, rd;
  logic [7:0]  n_store, depth, n_fault;
  int          mismatches = 0;
  int          n_checks = 0;
  logic [63:0] indef [3] = '{FSI_INDEF16, FSI_INDEF32, FSI_INDEF64};
  fsi_case_t   cases [11] = '{
    '{80'hC00E_8000_0000_0000_0000, FSI_SIZE_16, 2'h0, 64'h8000, 2'h0},
    '{80'h400E_8000_0000_0000_0000, FSI_SIZE_16, 2'h0, 64'h8000, 2'h1},
    '{80'hC00E_8000_8000_0000_0000, FSI_SIZE_16, 2'h1, 64'h8000, 2'h1},
    '{80'hC00E_8000_8000_0000_0000, FSI_SIZE_16, 2'h2, 64'h8000, 2'h2},
    '{80'h3FFF_C000_0000_0000_0000, FSI_SIZE_32, 2'h0, 64'h2, 2'h2},
    '{80'h3FFF_C000_0000_0000_0000, FSI_SIZE_32, 2'h3, 64'h1, 2'h2},
    '{80'hC00E_8000_8000_0000_0000, FSI_SIZE_32, 2'h0, 64'hFFFF_8000, 2'h2},
    '{80'hC020_8000_0000_0000_0000, FSI_SIZE_32, 2'h3, 64'h8000_0000, 2'h1},
    '{80'h400D_FFFE_0000_0000_0000, FSI_SIZE_16, 2'h0, 64'h7FFF, 2'h0},
    '{80'h400D_FFFF_0000_0000_0000, FSI_SIZE_16, 2'h0, 64'h8000, 2'h1},
    '{80'h7FFF_C000_0000_0000_0000, FSI_SIZE_64, 2'h0, FSI_INDEF64, 2'h1}};

  always #2 clk_i = ~clk_i;

  fsi_store_convert u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cvt_valid_i(cvt_valid_i),
    .cvt_operand_i(cvt_operand_i), .cvt_size_i(cvt_size_i), .cvt_pop_i(cvt_pop_i),
    .store_valid_o(store_valid_o), .store_data_o(store_data_o), .store_size_o(store_size_o),
    .pop_o(pop_o), .fault_o(fault_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

  fsi_store_model u_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .store_valid_i(store_valid_o),
    .store_data_i(store_data_o), .pop_i(pop_o), .fault_i(fault_o), .mem_word_o(mem_word),
    .n_store_o(n_store), .depth_o(depth), .n_fault_o(n_fault));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic cvt(input logic [79:0] op, input fsi_size_t sz, input logic pop);
    @(posedge clk_i);
    cvt_operand_i <= op;
    cvt_size_i    <= sz;
    cvt_pop_i     <= pop;
    cvt_valid_i   <= 1'b1;
    @(posedge clk_i);
    cvt_valid_i <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_masked();
    for (int r = 0; r < 4; r++) begin
      reg_wr(FSI_ADDR_CTRL, {29'h0, 1'b1, 2'(r)});
      for (int s = 0; s < 3; s++) begin
        cvt(NEG_HUGE, fsi_size_t'(s), 1'b0);
        chk("store_valid", 64'h1, {63'h0, store_valid_o});
        chk("store_data", indef[s], store_data_o);
        chk("store_size", 64'(s), {62'h0, store_size_o});
        reg_rd(FSI_ADDR_STATUS, rd);
        chk("status", 64'h5, {61'h0, rd[2:0]});
      end
    end
    $display("test masked overflow done");
  endtask

  task automatic test_rounding();
    foreach (cases[i]) begin
      reg_wr(FSI_ADDR_CTRL, {29'h0, 1'b1, cases[i].rm});
      cvt(cases[i].op, cases[i].sz, 1'b0);
      chk("store_data", cases[i].dat, store_data_o);
      reg_rd(FSI_ADDR_STATUS, rd);
      chk("status", {61'h0, 1'b1, cases[i].st}, {61'h0, rd[2:0]});
    end
    $display("test rounding done");
  endtask

  task automatic test_pop();
    cvt(NEG_HUGE, FSI_SIZE_32, 1'b1);
    chk("pop", 64'h1, {63'h0, pop_o});
    #4;
    chk("depth", 64'h07, {56'h0, depth});
    chk("mem word", FSI_INDEF32, mem_word);
    $display("test pop done");
  endtask

  task automatic test_unmasked();
    reg_wr(FSI_ADDR_MASK, 32'h1);
    reg_rd(FSI_ADDR_MASK, rd);
    chk("mask", 64'h1, {32'h0, rd});
    for (int r = 0; r < 4; r++) begin
      reg_wr(FSI_ADDR_CTRL, {30'h0, 2'(r)});
      cvt(NEG_HUGE, FSI_SIZE_16, 1'b1);
      chk("fault", 64'h1, {63'h0, fault_o});
      chk("no store", 64'h0, {62'h0, store_valid_o, pop_o});
      #4;
      chk("irq high", 64'h1, {63'h0, irq_o});
      reg_rd(FSI_ADDR_STATUS, rd);
      chk("status", 64'h5, {61'h0, rd[2:0]});
      chk("irq low", 64'h0, {63'h0, irq_o});
    end
    chk("stores", 64'h18, {56'h0, n_store});
    chk("depth", 64'h07, {56'h0, depth});
    chk("mem word", FSI_INDEF32, mem_word);
    chk("faults", 64'h4, {56'h0, n_fault});
    $display("test unmasked done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    reg_rd(FSI_ADDR_CTRL, rd);
    chk("ctrl reset", 64'h4, {32'h0, rd});
    reg_rd(8'h0C, rd);
    chk("unmapped", 64'h0, {32'h0, rd});
    test_masked();
    test_rounding();
    test_pop();
    test_unmasked();
    conclude();
  end

  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
